// [inc/t16_pkg.sv]
// Purpose: shared constants and types of the 16-bit timer data/mask block
// Assumes: 8-bit cpu data-space bus, byte addresses
// Notes: flag register sits at its printed data-space offset
package t16_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 16;
  // register byte offsets
  localparam logic [7:0] OFS_FLAGS = 8'h36;
  localparam logic [7:0] OFS_MASK = 8'h6f;
  localparam logic [7:0] OFS_COUNT = 8'h84;
  localparam logic [7:0] OFS_CAPTURE = 8'h86;
  localparam logic [7:0] OFS_CMP_A = 8'h88;
  localparam logic [7:0] OFS_CMP_B = 8'h8a;
  localparam logic [7:0] OFS_HIGH = 8'h01;
  // bit positions in mask and flag registers
  localparam int unsigned BIT_OVF = 0;
  localparam int unsigned BIT_CMP_A = 1;
  localparam int unsigned BIT_CMP_B = 2;
  localparam int unsigned BIT_CAP = 5;
  localparam logic [7:0] IRQ_BITS_MASK = 8'h27;
  // reset values, full count and count step
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] MAX_COUNT = 16'hffff;
  localparam logic [15:0] ONE_COUNT = 16'h0001;

  // one cpu access per cycle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } t16_bus_req_t;

  // where the counter wraps
  typedef enum logic [0:0] {
    T16_TOP_MAX = 1'b0,
    T16_TOP_CAPTURE = 1'b1
  } t16_top_t;
endpackage : t16_pkg

// [core/t16_timer.sv]
// Purpose: 16-bit timer data registers, shared high-byte latch, capture, compare and irq mask
// Assumes: cpu bus and tick_i on clk_i; capture and comparator inputs asynchronous
// Notes: read data appears one cycle after the read strobe
// How it works
// - low byte at base offset, high byte at base plus one.
// - cpu reads and writes count value; a write loads the counter directly.
// - every 16-bit access goes through one 8-bit high-byte latch.
// - count, capture and both compares share that single latch.
// - a count write suppresses compare matches on the next timer tick.
// - qualifying capture event copies the counter into capture value.
// - capture value may serve as counter top instead of capturing.
// - capture read returns both bytes from one instant via the latch.
// - compare writes update both bytes together.
// - compare A checked every tick; match sets flag and toggles pin A.
// - compare B checked every tick; match sets flag and toggles pin B.
// - capture irq enable at mask bit 5 gates capture irq.
// - compare B irq enable at mask bit 2 gates compare B irq.
// - compare A irq enable at mask bit 1 gates compare A irq.
// - overflow irq enable at mask bit 0 gates overflow irq.
// - capture flag sets on event, clears by vector ack or writing one.
module t16_timer (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire t16_pkg::t16_bus_req_t bus_req_i,
  output logic [7:0] bus_rdata_o,
  input wire logic tick_i,
  input wire t16_pkg::t16_top_t top_sel_i,
  input wire logic capture_rising_i,
  input wire logic acomp_sel_i,
  input wire logic acomp_i,
  input wire logic capture_input_pin_i,
  input wire logic global_irq_en_i,
  input wire logic [3:0] irq_ack_i,
  output logic [3:0] irq_o,
  output logic compare_a_output_pin_o,
  output logic compare_b_output_pin_o
);
  import t16_pkg::*;

  // true when addr hits the byte (hi selects base plus one) of a pair
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] base, input logic hi);
    hit = (addr == (hi ? base + OFS_HIGH : base));
  endfunction : hit

  logic [15:0] count_reg, count_next;
  logic [15:0] capture_reg, capture_next;
  logic [15:0] cmp_a_reg, cmp_a_next;
  logic [15:0] cmp_b_reg, cmp_b_next;
  logic [7:0] latch_reg, latch_next;
  logic [7:0] mask_reg, mask_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] ack_clr;
  logic [7:0] rdata_reg, rdata_next;
  logic [3:0] irq_reg, irq_next;
  logic block_reg, block_next;
  logic pin_a_reg, pin_a_next;
  logic pin_b_reg, pin_b_next;
  logic [1:0] cap_sync_reg;
  logic [1:0] cmp_sync_reg;
  logic cap_src, cap_prev_reg, cap_event;
  logic [15:0] top_val;
  logic match_a, match_b, at_top;

  // capture source synchronisers; stage 0 only feeds stage 1
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cap_sync_reg <= 2'h0;
      cmp_sync_reg <= 2'h0;
      cap_prev_reg <= 1'b0;
    end else if (ce_i) begin
      cap_sync_reg <= {cap_sync_reg[0], capture_input_pin_i};
      cmp_sync_reg <= {cmp_sync_reg[0], acomp_i};
      cap_prev_reg <= cap_src;
    end
  end

  // edge qualification of the selected capture source
  assign cap_src = acomp_sel_i ? cmp_sync_reg[1] : cap_sync_reg[1];
  assign cap_event = (top_sel_i == T16_TOP_MAX) &&
                     (capture_rising_i ? (cap_src && !cap_prev_reg) : (!cap_src && cap_prev_reg));

  // top and compare decode
  assign top_val = (top_sel_i == T16_TOP_CAPTURE) ? capture_reg : MAX_COUNT;
  assign at_top = (count_reg == top_val);
  assign match_a = tick_i && !block_reg && (count_reg == cmp_a_reg);
  assign match_b = tick_i && !block_reg && (count_reg == cmp_b_reg);

  // register file, counter and flag next values
  always_comb begin
    count_next = count_reg;
    capture_next = capture_reg;
    cmp_a_next = cmp_a_reg;
    cmp_b_next = cmp_b_reg;
    latch_next = latch_reg;
    mask_next = mask_reg;
    flags_next = flags_reg;
    rdata_next = RST_BYTE;
    block_next = block_reg;
    pin_a_next = pin_a_reg ^ match_a;
    pin_b_next = pin_b_reg ^ match_b;
    // counter runs on each timer tick and clears the write block
    if (tick_i) begin
      block_next = 1'b0;
      count_next = at_top ? RST_WORD : count_reg + ONE_COUNT;
    end
    if (cap_event) begin
      capture_next = count_reg;
    end
    // vector acks clear their own flags first, so events below win
    ack_clr = RST_BYTE;
    ack_clr[BIT_CAP] = irq_ack_i[3];
    ack_clr[BIT_CMP_B] = irq_ack_i[2];
    ack_clr[BIT_CMP_A] = irq_ack_i[1];
    ack_clr[BIT_OVF] = irq_ack_i[0];
    flags_next = flags_reg & ~ack_clr;
    if (bus_req_i.we && hit(bus_req_i.addr, OFS_FLAGS, 1'b0)) begin
      flags_next = flags_next & ~(bus_req_i.wdata & IRQ_BITS_MASK);
    end
    // cpu writes: high bytes fill the latch, low bytes commit
    if (bus_req_i.we) begin
      if (hit(bus_req_i.addr, OFS_MASK, 1'b0)) begin
        mask_next = bus_req_i.wdata & IRQ_BITS_MASK;
      end
      if (hit(bus_req_i.addr, OFS_COUNT, 1'b1) || hit(bus_req_i.addr, OFS_CAPTURE, 1'b1) ||
          hit(bus_req_i.addr, OFS_CMP_A, 1'b1) || hit(bus_req_i.addr, OFS_CMP_B, 1'b1)) begin
        latch_next = bus_req_i.wdata;
      end
      if (hit(bus_req_i.addr, OFS_COUNT, 1'b0)) begin
        count_next = {latch_reg, bus_req_i.wdata};
        block_next = 1'b1;
      end
      if (hit(bus_req_i.addr, OFS_CAPTURE, 1'b0)) begin
        capture_next = {latch_reg, bus_req_i.wdata};
      end
      if (hit(bus_req_i.addr, OFS_CMP_A, 1'b0)) begin
        cmp_a_next = {latch_reg, bus_req_i.wdata};
      end
      if (hit(bus_req_i.addr, OFS_CMP_B, 1'b0)) begin
        cmp_b_next = {latch_reg, bus_req_i.wdata};
      end
    end else if (bus_req_i.re) begin
      // low read returns low byte and parks the high byte in the latch
      if (hit(bus_req_i.addr, OFS_COUNT, 1'b0)) begin
        rdata_next = count_reg[7:0];
        latch_next = count_reg[15:8];
      end else if (hit(bus_req_i.addr, OFS_CAPTURE, 1'b0)) begin
        rdata_next = capture_reg[7:0];
        latch_next = capture_reg[15:8];
      end else if (hit(bus_req_i.addr, OFS_CMP_A, 1'b0)) begin
        rdata_next = cmp_a_reg[7:0];
        latch_next = cmp_a_reg[15:8];
      end else if (hit(bus_req_i.addr, OFS_CMP_B, 1'b0)) begin
        rdata_next = cmp_b_reg[7:0];
        latch_next = cmp_b_reg[15:8];
      end else if (hit(bus_req_i.addr, OFS_COUNT, 1'b1) || hit(bus_req_i.addr, OFS_CAPTURE, 1'b1) ||
                   hit(bus_req_i.addr, OFS_CMP_A, 1'b1) || hit(bus_req_i.addr, OFS_CMP_B, 1'b1)) begin
        rdata_next = latch_reg;
      end else if (hit(bus_req_i.addr, OFS_MASK, 1'b0)) begin
        rdata_next = mask_reg;
      end else if (hit(bus_req_i.addr, OFS_FLAGS, 1'b0)) begin
        rdata_next = flags_reg;
      end
    end
    // hardware events set flags; set wins over any clear
    if (cap_event || (tick_i && at_top && top_sel_i == T16_TOP_CAPTURE)) begin
      flags_next[BIT_CAP] = 1'b1;
    end
    if (match_a) begin
      flags_next[BIT_CMP_A] = 1'b1;
    end
    if (match_b) begin
      flags_next[BIT_CMP_B] = 1'b1;
    end
    if (tick_i && at_top && top_sel_i == T16_TOP_MAX) begin
      flags_next[BIT_OVF] = 1'b1;
    end
    // irq requests: flag and enable and global enable
    irq_next[3] = global_irq_en_i && flags_next[BIT_CAP] && mask_next[BIT_CAP];
    irq_next[2] = global_irq_en_i && flags_next[BIT_CMP_B] && mask_next[BIT_CMP_B];
    irq_next[1] = global_irq_en_i && flags_next[BIT_CMP_A] && mask_next[BIT_CMP_A];
    irq_next[0] = global_irq_en_i && flags_next[BIT_OVF] && mask_next[BIT_OVF];
  end

  // state registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_reg <= RST_WORD;
      capture_reg <= RST_WORD;
      cmp_a_reg <= RST_WORD;
      cmp_b_reg <= RST_WORD;
      latch_reg <= RST_BYTE;
      mask_reg <= RST_BYTE;
      flags_reg <= RST_BYTE;
      rdata_reg <= RST_BYTE;
      irq_reg <= 4'h0;
      block_reg <= 1'b0;
      pin_a_reg <= 1'b0;
      pin_b_reg <= 1'b0;
    end else if (ce_i) begin
      count_reg <= count_next;
      capture_reg <= capture_next;
      cmp_a_reg <= cmp_a_next;
      cmp_b_reg <= cmp_b_next;
      latch_reg <= latch_next;
      mask_reg <= mask_next;
      flags_reg <= flags_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      block_reg <= block_next;
      pin_a_reg <= pin_a_next;
      pin_b_reg <= pin_b_next;
    end
  end

  assign bus_rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign compare_a_output_pin_o = pin_a_reg;
  assign compare_b_output_pin_o = pin_b_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  count_low_commit_a: assert property (ce_i && bus_req_i.we && bus_req_i.addr == OFS_COUNT |=>
    count_reg == {$past(latch_reg), $past(bus_req_i.wdata)}) else $error("count write not committed");
  high_write_latch_a: assert property (ce_i && bus_req_i.we && bus_req_i.addr == OFS_CMP_B + OFS_HIGH |=>
    latch_reg == $past(bus_req_i.wdata)) else $error("high write missed latch");
  low_read_latch_a: assert property (ce_i && bus_req_i.re && !bus_req_i.we && bus_req_i.addr == OFS_CAPTURE |=>
    latch_reg == $past(capture_reg[15:8]) && bus_rdata_o == $past(capture_reg[7:0])) else $error("capture read split");
  cmp_write_whole_a: assert property (ce_i && $changed(cmp_a_reg) |->
    $past(bus_req_i.we) && $past(bus_req_i.addr) == OFS_CMP_A) else $error("compare changed without low write");
  write_blocks_match_a: assert property (ce_i && bus_req_i.we && bus_req_i.addr == OFS_COUNT ##1 ce_i && tick_i
    |=> $stable(pin_a_reg) && $stable(pin_b_reg)) else $error("match after count write");
  gap_tick_block_a: assert property (ce_i && bus_req_i.we && bus_req_i.addr == OFS_COUNT ##1 ce_i && !tick_i
    ##1 ce_i && tick_i |=> $stable(pin_a_reg) && $stable(pin_b_reg)) else $error("match after idle then tick");
  match_a_toggle_a: assert property (ce_i && match_a |=> pin_a_reg != $past(pin_a_reg) && flags_reg[BIT_CMP_A])
    else $error("compare A match lost");
  match_b_flag_a: assert property (ce_i && match_b |=> flags_reg[BIT_CMP_B]) else $error("compare B flag lost");
  capture_copy_a: assert property (ce_i && cap_event && !bus_req_i.we |=>
    capture_reg == $past(count_reg) && flags_reg[BIT_CAP]) else $error("capture not taken");
  capture_irq_a: assert property (ce_i && irq_o[3] |-> mask_reg[BIT_CAP] && flags_reg[BIT_CAP])
    else $error("capture irq without enable");
  ovf_irq_gate_a: assert property (ce_i && flags_reg[BIT_OVF] && mask_reg[BIT_OVF] && global_irq_en_i
    && $stable(global_irq_en_i) |-> irq_o[0]) else $error("overflow irq missing");
endmodule : t16_timer

// [dv/t16_cpu_model.sv]
// Purpose: cpu data-space master model for the timer data and mask block
// Assumes: one access per cycle; strobes change just after rising clk_i
// Notes: words go high byte first on write, low byte first on read
module t16_cpu_model
  import t16_pkg::*;
(
  input wire logic clk_i,
  output t16_pkg::t16_bus_req_t bus_req_o,
  input wire logic [7:0] bus_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_req_o = '0;
  end
  // one byte access, held up to the taking edge, data picked after it
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
    @(posedge clk_i);
    bus_req_o <= '{addr: a, wdata: d, we: w, re: !w};
    @(posedge clk_i);
    bus_req_o <= '0;
    #1 q = bus_rdata_i;
  endtask : xfer
  // high byte to the shared latch, then low byte commits the word
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    logic [7:0] q;
    xfer(a + OFS_HIGH, v[15:8], 1'b1, q);
    xfer(a, v[7:0], 1'b1, q);
  endtask : wr16
  // low byte read loads the latch, high byte read returns it
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    xfer(a, 8'h00, 1'b0, v[7:0]);
    xfer(a + OFS_HIGH, 8'h00, 1'b0, v[15:8]);
  endtask : rd16
endmodule : t16_cpu_model

// [dv/t16_timer_tb.sv]
// Purpose: self-checking bench for the 16-bit timer data and mask block
// Assumes: tick_i driven by the bench; ce_i dropped once to check the freeze
// Notes: count is only written while no tick is pending
module t16_timer_tb;
  import t16_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, tick_i = 1'b0, gie = 1'b1;
  logic cap_rise = 1'b1, acomp_sel = 1'b0, acomp = 1'b0, cap_pin = 1'b0;
  logic ce = 1'b1;
  logic [3:0] ack = 4'h0;
  t16_top_t top_sel = T16_TOP_MAX;
  t16_bus_req_t bus_req;
  logic [7:0] rdata, b;
  logic [3:0] irq;
  logic pin_a, pin_b;
  logic [15:0] v;
  int num_errors = 0, n_tests = 0;
  t16_cpu_model cpu (.clk_i(clk_i), .bus_req_o(bus_req), .bus_rdata_i(rdata));
  t16_timer dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .bus_req_i(bus_req),
    .bus_rdata_o(rdata), .tick_i(tick_i), .top_sel_i(top_sel), .capture_rising_i(cap_rise),
    .acomp_sel_i(acomp_sel), .acomp_i(acomp), .capture_input_pin_i(cap_pin),
    .global_irq_en_i(gie), .irq_ack_i(ack), .irq_o(irq), .compare_a_output_pin_o(pin_a),
    .compare_b_output_pin_o(pin_b));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  // spaced timer ticks, outputs settled afterwards
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i) tick_i <= 1'b1;
      @(posedge clk_i) tick_i <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic pulse_ack(input logic [3:0] m);
    @(posedge clk_i) ack <= m;
    @(posedge clk_i) ack <= 4'h0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : pulse_ack
  initial begin
    #50us;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // reset values, then a word through every pair
    for (int i = 0; i < 4; i++) begin
      cpu.rd16(OFS_COUNT + 8'(2 * i), v);
      check("reset word", v, RST_WORD);
      cpu.wr16(OFS_COUNT + 8'(2 * i), 16'h1234 + 16'(i * 16'h1111));
      cpu.rd16(OFS_COUNT + 8'(2 * i), v);
      check("word rw", v, 16'h1234 + 16'(i * 16'h1111));
    end
    // one latch for every pair
    cpu.xfer(OFS_CMP_A + OFS_HIGH, 8'hab, 1'b1, b);
    cpu.xfer(OFS_CMP_B, 8'hcd, 1'b1, b);
    cpu.rd16(OFS_CMP_B, v);
    check("latch write", v, 16'habcd);
    cpu.xfer(OFS_COUNT, 8'h00, 1'b0, b);
    cpu.xfer(OFS_CMP_A + OFS_HIGH, 8'h00, 1'b0, b);
    check("latch read", {8'h00, b}, 16'h0012);
    // mask keeps only its four bits, unmapped place reads zero
    cpu.xfer(OFS_MASK, 8'h00, 1'b0, b);
    check("mask reset", {8'h00, b}, 16'h0000);
    cpu.xfer(OFS_MASK, 8'hff, 1'b1, b);
    cpu.xfer(OFS_MASK, 8'h00, 1'b0, b);
    check("mask bits", {8'h00, b}, {8'h00, IRQ_BITS_MASK});
    cpu.xfer(8'h80, 8'h5a, 1'b1, b);
    cpu.xfer(8'h80, 8'h00, 1'b0, b);
    check("unmapped", {8'h00, b}, 16'h0000);
    // compares: a count write hides the next tick's match
    cpu.wr16(OFS_CMP_A, 16'h0005);
    cpu.wr16(OFS_CMP_B, 16'h0006);
    cpu.wr16(OFS_COUNT, 16'h0005);
    tick(1);
    check("blocked a", {15'h0, pin_a}, 16'h0000);
    tick(1);
    check("match b", {14'h0, pin_b, pin_a}, 16'h0002);
    check("irq b", {12'h0, irq}, 16'h0004);
    cpu.wr16(OFS_COUNT, 16'h0004);
    tick(2);
    check("match a", {14'h0, pin_b, pin_a}, 16'h0003);
    check("irq a", {12'h0, irq}, 16'h0006);
    cpu.xfer(OFS_FLAGS, 8'h06, 1'b1, b);
    #20;
    check("flags cleared", {12'h0, irq}, 16'h0000);
    // overflow raises its irq, vector ack clears it
    cpu.wr16(OFS_COUNT, MAX_COUNT);
    tick(1);
    check("overflow irq", {12'h0, irq}, 16'h0001);
    pulse_ack(4'h1);
    check("overflow ack", {12'h0, irq}, 16'h0000);
    // clock enable low freezes the counter through two ticks
    cpu.wr16(OFS_COUNT, 16'h0100);
    @(posedge clk_i) ce <= 1'b0;
    tick(2);
    @(posedge clk_i) ce <= 1'b1;
    cpu.rd16(OFS_COUNT, v);
    check("ce freeze", v, 16'h0100);
    // pin capture with global enable off, then on
    cpu.wr16(OFS_COUNT, 16'h0abc);
    @(posedge clk_i) gie <= 1'b0;
    cap_pin <= 1'b1;
    repeat (8) @(posedge clk_i);
    cpu.rd16(OFS_CAPTURE, v);
    check("pin capture", v, 16'h0abc);
    check("irq gated", {12'h0, irq}, 16'h0000);
    @(posedge clk_i) gie <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 check("capture irq", {12'h0, irq}, 16'h0008);
    cpu.xfer(OFS_FLAGS, 8'h20, 1'b1, b);
    cpu.xfer(OFS_FLAGS, 8'h00, 1'b0, b);
    check("flag w1c", {8'h00, b}, 16'h0000);
    // comparator source on its falling edge
    cpu.wr16(OFS_COUNT, 16'h0def);
    @(posedge clk_i) acomp <= 1'b1;
    repeat (4) @(posedge clk_i);
    acomp_sel <= 1'b1;
    cap_rise <= 1'b0;
    repeat (4) @(posedge clk_i);
    acomp <= 1'b0;
    repeat (8) @(posedge clk_i);
    cpu.rd16(OFS_CAPTURE, v);
    check("comparator capture", v, 16'h0def);
    pulse_ack(4'h8);
    cpu.xfer(OFS_FLAGS, 8'h00, 1'b0, b);
    check("capture ack", {8'h00, b}, 16'h0000);
    // capture value as counter top
    cpu.wr16(OFS_CAPTURE, 16'h0002);
    cpu.wr16(OFS_COUNT, RST_WORD);
    @(posedge clk_i) top_sel <= T16_TOP_CAPTURE;
    tick(3);
    cpu.rd16(OFS_COUNT, v);
    check("capture top wrap", v, RST_WORD);
    check("top flag irq", {12'h0, irq}, 16'h0008);
    close_out();
  end
endmodule : t16_timer_tb
